// ---- hdl/sfc_converter.sv ----
`timescale 1ns/1ps
`include "sfc_regs.svh"

module sfc_converter
  import sfc_pkg::*;
#(
  parameter int SEQ_PULSE_CYCLES = `SFC_SEQ_PULSE_CYC
) (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // decoded control lines from the upstream decoder
  input wire logic [`SFC_CTL_W-1:0] decoded_control_lines,
  // sensor pins and the fast counting clock, all asynchronous
  input wire logic sensor_static,
  input wire logic sensor_total,
  input wire logic hs_clock,
  // processor input side
  input wire logic [`SFC_IDX_W-1:0] index_word,
  input wire logic input_strobe,
  input wire logic input_data_enable,
  output logic [`SFC_HALF_W-1:0] input_data,
  output logic input_data_valid,
  // count sequence lines
  output logic count_seq_static,
  output logic count_seq_total,
  // channel select pulses toward the squarer
  output logic static_channel_select,
  output logic total_channel_select,
  // sensor routing
  output logic route_static,
  output logic route_total,
  output logic squarer_in,
  // converter latch strobe toward the control card
  output logic converter_latch_strobe,
  // status
  output logic measure_busy,
  output logic measure_done,
  output logic [`SFC_CYC_W-1:0] cycle_count
);

  // ****************************************************************
  // elaboration checks
  // ****************************************************************
  localparam int SEQ_MAX = (1 << `SFC_SEQ_W) - 1;

  if (SEQ_PULSE_CYCLES < 1 || SEQ_PULSE_CYCLES > SEQ_MAX) begin : g_bad
    $error("SEQ_PULSE_CYCLES out of range");
  end

  localparam logic [`SFC_SEQ_W-1:0] SEQ_LOAD =
    `SFC_SEQ_W'(SEQ_PULSE_CYCLES);

  // ****************************************************************
  // control line decoding
  // ****************************************************************

  // one decoder used for every control code
  function automatic logic ctl_hit(
    input logic [`SFC_CTL_W-1:0] now,
    input logic [`SFC_CTL_W-1:0] prev,
    input logic [`SFC_CTL_W-1:0] code
  );
    // a code counts once when it appears, not while it stands
    return (now == code) && (prev != code);
  endfunction : ctl_hit

  sfc_main_t r_q;
  sfc_main_t r_d;

  logic start_static;
  logic start_total;
  logic start_any;
  logic latch_hit;

  assign start_static =
    ctl_hit(decoded_control_lines, r_q.ctl_prev, `SFC_CTL_STATIC);
  assign start_total =
    ctl_hit(decoded_control_lines, r_q.ctl_prev, `SFC_CTL_TOTAL);
  assign start_any = start_static || start_total;
  assign latch_hit =
    ctl_hit(decoded_control_lines, r_q.ctl_prev, `SFC_CTL_LATCH);

  // ****************************************************************
  // synchronised pins
  // ****************************************************************

  // stage 0 is the first synchroniser flop; only stage 1 reads it
  logic [2:0] sen_sel;
  logic sen_high;
  logic sen_rise;
  logic hs_rise;

  // only the channel picked at start feeds the period logic
  assign sen_sel = r_q.chan ? r_q.sen_t : r_q.sen_s;
  assign sen_high = sen_sel[1];
  assign sen_rise = sen_sel[1] && !sen_sel[2];
  // limitation: 37.5 MHz sampled at 100 MHz, edges can be missed
  // when jitter closes the sample window; trade for one clock
  assign hs_rise = r_q.hs[1] && !r_q.hs[2];

  // ****************************************************************
  // cycle counter
  // ****************************************************************
  logic cyc_advance;
  logic cyc_wrap;
  logic [`SFC_CYC_W-1:0] cyc_load_value;

  // a rising sensor edge closes one complete period
  assign cyc_advance = (r_q.state == SFC_COUNT) && sen_rise;
  assign cyc_load_value = start_total ? `SFC_PRELOAD_TOTAL
                                      : `SFC_PRELOAD_STATIC;

  sfc_cycle_counter u_cycle (
    .clk(clk),
    .reset(reset),
    .load(start_any),
    .load_value(cyc_load_value),
    .advance(cyc_advance),
    .count(cycle_count),
    .wrap(cyc_wrap)
  );

  // ****************************************************************
  // next state
  // ****************************************************************
  always_comb begin
    r_d = r_q;
    r_d.ctl_prev = decoded_control_lines;
    r_d.sel_static = 1'b0;
    r_d.sel_total = 1'b0;
    r_d.latch_strobe = latch_hit;
    r_d.rd_valid = 1'b0;

    // synchroniser chains: two flops, then one more for edges
    r_d.sen_s = {r_q.sen_s[1:0], sensor_static};
    r_d.sen_t = {r_q.sen_t[1:0], sensor_total};
    r_d.hs = {r_q.hs[1:0], hs_clock};

    // sequence pulse timer, retriggered by every start
    if (r_q.seq_cnt != '0) begin
      r_d.seq_cnt = r_q.seq_cnt - 1'b1;
      if (r_q.seq_cnt == `SFC_SEQ_W'(1)) begin
        r_d.seq_static = 1'b0;
        r_d.seq_total = 1'b0;
      end
    end

    // measurement control
    if (start_any) begin
      r_d.state = SFC_ARM;
      r_d.chan = start_total;
      r_d.acc = '0;
      r_d.seq_cnt = SEQ_LOAD;
      r_d.seq_static = start_static;
      r_d.seq_total = start_total;
      r_d.sel_static = start_static;
      r_d.sel_total = start_total;
    end else begin
      case (r_q.state)
        SFC_IDLE: begin
          r_d.state = SFC_IDLE;
        end
        SFC_ARM: begin
          // wait for a period boundary so only whole periods count
          if (sen_rise) begin
            r_d.state = SFC_COUNT;
          end
        end
        SFC_COUNT: begin
          if (cyc_wrap) begin
            r_d.state = SFC_DONE;
          end else if (hs_rise && sen_high) begin
            r_d.acc = r_q.acc + 1'b1;
          end
        end
        SFC_DONE: begin
          // result stays frozen; reading does not disturb it
          r_d.state = SFC_DONE;
        end
        default: begin
          r_d.state = SFC_IDLE;
        end
      endcase
    end

    // squarer feed: the chosen sensor only, silent when idle
    if (r_q.state == SFC_IDLE) begin
      r_d.squarer = 1'b0;
    end else begin
      r_d.squarer = sen_high;
    end

    // request register for the half to be read
    if (input_strobe) begin
      r_d.req_fine = index_word[`SFC_REQ_FINE_BIT];
    end

    // multiplexer onto the input data bus
    if (input_data_enable) begin
      r_d.rd_valid = 1'b1;
      if (r_q.req_fine) begin
        r_d.rd_data = r_q.acc[`SFC_HALF_W-1:0];
      end else begin
        r_d.rd_data = r_q.acc[`SFC_ACC_W-1:`SFC_HALF_W];
      end
    end
  end

  // ****************************************************************
  // state register
  // ****************************************************************
  always_ff @(posedge clk) begin
    if (reset) begin
      r_q <= '0;
    end else begin
      r_q <= r_d;
    end
  end

  // ****************************************************************
  // outputs
  // ****************************************************************
  assign input_data = r_q.rd_data;
  assign input_data_valid = r_q.rd_valid;
  assign count_seq_static = r_q.seq_static;
  assign count_seq_total = r_q.seq_total;
  assign static_channel_select = r_q.sel_static;
  assign total_channel_select = r_q.sel_total;
  assign converter_latch_strobe = r_q.latch_strobe;
  assign squarer_in = r_q.squarer;
  // routing follows the latched channel for the whole measurement
  assign route_static = (r_q.state != SFC_IDLE) && !r_q.chan;
  assign route_total = (r_q.state != SFC_IDLE) && r_q.chan;
  assign measure_busy = (r_q.state == SFC_ARM) ||
                        (r_q.state == SFC_COUNT);
  assign measure_done = (r_q.state == SFC_DONE);

endmodule : sfc_converter

// ---- hdl/sfc_cycle_counter.sv ----
`timescale 1ns/1ps
`include "sfc_regs.svh"

module sfc_cycle_counter
  import sfc_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // preload
  input wire logic load,
  input wire logic [`SFC_CYC_W-1:0] load_value,
  // one complete sensor period seen
  input wire logic advance,
  // state
  output logic [`SFC_CYC_W-1:0] count,
  output logic wrap
);

  sfc_cyc_t r_q;
  sfc_cyc_t r_d;

  // wrap marks the step from the top value back to zero
  assign wrap = advance && !load && (r_q.count == `SFC_CYC_TOP);
  assign count = r_q.count;

  // preload wins over advance so a restart is never half counted
  always_comb begin
    r_d = r_q;
    if (load) begin
      r_d.count = load_value;
    end else if (advance) begin
      r_d.count = r_q.count + 8'h01;
    end
  end

  // state register
  always_ff @(posedge clk) begin
    if (reset) begin
      r_q <= '0;
    end else begin
      r_q <= r_d;
    end
  end

endmodule : sfc_cycle_counter

// ---- hdl/sfc_pkg.sv ----
`include "sfc_regs.svh"

package sfc_pkg;

  // ****************************************************************
  // measurement states
  // ****************************************************************
  typedef enum logic [1:0] {
    SFC_IDLE = 2'b00,
    SFC_ARM = 2'b01,
    SFC_COUNT = 2'b10,
    SFC_DONE = 2'b11
  } sfc_state_t;

  // state of the cycle counter
  typedef struct packed {
    logic [`SFC_CYC_W-1:0] count;
  } sfc_cyc_t;

  // state of the converter top
  typedef struct packed {
    sfc_state_t state;
    logic [`SFC_CTL_W-1:0] ctl_prev;
    logic chan;
    logic [2:0] sen_s;
    logic [2:0] sen_t;
    logic [2:0] hs;
    logic squarer;
    logic [`SFC_ACC_W-1:0] acc;
    logic [`SFC_SEQ_W-1:0] seq_cnt;
    logic seq_static;
    logic seq_total;
    logic sel_static;
    logic sel_total;
    logic latch_strobe;
    logic req_fine;
    logic [`SFC_HALF_W-1:0] rd_data;
    logic rd_valid;
  } sfc_main_t;

endpackage : sfc_pkg

// ---- hdl/sfc_regs.svh ----
`ifndef SFC_REGS_SVH
`define SFC_REGS_SVH

// ****************************************************************
// clock and timing
// ****************************************************************
`define SFC_CLK_PERIOD_NS 10
// sequence pulse length in ns (1.4 ms)
`define SFC_SEQ_PULSE_NS 1400000
// rounded up to whole clock cycles
`define SFC_SEQ_PULSE_CYC \
  ((`SFC_SEQ_PULSE_NS + `SFC_CLK_PERIOD_NS - 1) / `SFC_CLK_PERIOD_NS)
`define SFC_SEQ_W 18

// ****************************************************************
// decoded control line codes
// ****************************************************************
`define SFC_CTL_W 4
`define SFC_CTL_STATIC 4'h1
`define SFC_CTL_TOTAL 4'h2
`define SFC_CTL_LATCH 4'h3

// ****************************************************************
// request word and result layout
// ****************************************************************
`define SFC_IDX_W 8
`define SFC_REQ_FINE_BIT 0
`define SFC_ACC_W 16
`define SFC_HALF_W 8

// ****************************************************************
// cycle counter preloads
// ****************************************************************
`define SFC_CYC_W 8
`define SFC_PRELOAD_STATIC 8'hc7
`define SFC_PRELOAD_TOTAL 8'h5e
`define SFC_CYC_TOP 8'hff

`endif

// ---- testbench/sfc_converter_chk.sv ----
`timescale 1ns/1ps
`include "sfc_regs.svh"

// ********************
// port checker
// ********************
module sfc_converter_chk
  import sfc_pkg::*;
#(
  parameter int SEQ_PULSE_CYCLES = 20
) (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // requests
  input wire logic [`SFC_CTL_W-1:0] decoded_control_lines,
  input wire logic input_data_enable,
  // answers
  input wire logic input_data_valid,
  input wire logic count_seq_static,
  input wire logic count_seq_total,
  input wire logic static_channel_select,
  input wire logic total_channel_select,
  input wire logic route_static,
  input wire logic route_total,
  input wire logic converter_latch_strobe,
  input wire logic measure_done,
  input wire logic [`SFC_CYC_W-1:0] cycle_count
);
  logic [`SFC_SEQ_W-1:0] slen_q;
  logic seq_any;

  default clocking @(posedge clk); endclocking
  default disable iff (reset);

  // a select restarts the count, so a retriggered pulse is measured whole
  assign seq_any = count_seq_static | count_seq_total;
  always_ff @(posedge clk) begin
    if (reset || !seq_any) begin
      slen_q <= '0;
    end else if (static_channel_select || total_channel_select) begin
      slen_q <= 'h1;
    end else begin
      slen_q <= slen_q + 'h1;
    end
  end

  start_static_a: assert property (
    decoded_control_lines == `SFC_CTL_STATIC
    && $past(decoded_control_lines) != `SFC_CTL_STATIC
    |=> static_channel_select && count_seq_static && route_static)
    else $error("static start not answered");
  start_total_a: assert property (
    decoded_control_lines == `SFC_CTL_TOTAL
    && $past(decoded_control_lines) != `SFC_CTL_TOTAL
    |=> total_channel_select && count_seq_total && route_total)
    else $error("total start not answered");
  seq_length_a: assert property (
    $fell(seq_any) |-> slen_q == `SFC_SEQ_W'(SEQ_PULSE_CYCLES))
    else $error("sequence pulse length wrong");
  preload_static_a: assert property (
    static_channel_select |-> cycle_count == 8'hc7)
    else $error("static preload wrong");
  preload_total_a: assert property (
    total_channel_select |-> cycle_count == 8'h5e)
    else $error("total preload wrong");
  wrap_stop_a: assert property (
    $rose(measure_done) |-> $past(cycle_count) == 8'hff)
    else $error("stop without wrap from top");
  done_hold_a: assert property (
    measure_done ##1 measure_done |-> $stable(cycle_count))
    else $error("counter moved after stop");
  latch_pulse_a: assert property (
    decoded_control_lines == `SFC_CTL_LATCH
    && $past(decoded_control_lines) != `SFC_CTL_LATCH
    |=> converter_latch_strobe ##1 !converter_latch_strobe)
    else $error("latch strobe not one cycle");
  read_answer_a: assert property (
    input_data_enable |=> input_data_valid)
    else $error("read not answered");
  valid_cause_a: assert property (
    input_data_valid |-> $past(input_data_enable))
    else $error("valid without enable");
  one_route_a: assert property (
    !(route_static && route_total))
    else $error("both sensors routed");
endmodule : sfc_converter_chk

bind sfc_converter sfc_converter_chk #(
  .SEQ_PULSE_CYCLES(SEQ_PULSE_CYCLES)
) chk (.clk, .reset, .decoded_control_lines, .input_data_enable,
  .input_data_valid, .count_seq_static, .count_seq_total,
  .static_channel_select, .total_channel_select, .route_static,
  .route_total, .converter_latch_strobe, .measure_done, .cycle_count);

// ---- testbench/sfc_converter_tb.sv ----
`timescale 1ns/1ps
`include "sfc_regs.svh"

module sfc_converter_tb
  import sfc_pkg::*;
;
  localparam int SEQ = 20;
  // expected counts: periods counted times fast clock edges while the sensor is high, static and total
  localparam int EXP_S = (256 - `SFC_PRELOAD_STATIC) * 2;
  localparam int EXP_T = (256 - `SFC_PRELOAD_TOTAL) * 3;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic [`SFC_CTL_W-1:0] decoded_control_lines = 4'h0;
  logic [`SFC_IDX_W-1:0] index_word = 8'h00;
  logic input_strobe = 1'b0;
  logic input_data_enable = 1'b0;
  logic sensor_static, sensor_total, hs_clock, squarer_in;
  logic input_data_valid, count_seq_static, count_seq_total;
  logic static_channel_select, total_channel_select;
  logic route_static, route_total, converter_latch_strobe;
  logic measure_busy, measure_done;
  logic [7:0] input_data, cycle_count;
  logic [15:0] v;
  int miscompares = 0;
  int tests_run = 0;

  always #5 clk = ~clk;

  sfc_sensor_model sensors (.clk, .sensor_static, .sensor_total, .hs_clock);
  sfc_converter #(.SEQ_PULSE_CYCLES(SEQ)) dut (.clk, .reset,
    .decoded_control_lines, .sensor_static, .sensor_total, .hs_clock,
    .index_word, .input_strobe, .input_data_enable, .input_data,
    .input_data_valid, .count_seq_static, .count_seq_total,
    .static_channel_select, .total_channel_select, .route_static,
    .route_total, .squarer_in, .converter_latch_strobe, .measure_busy,
    .measure_done, .cycle_count);

  // ********************
  // compare and bus tasks
  // ********************
  task automatic check_bit(input logic got, input logic exp);
    tests_run++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED at %0t: flag mismatch", $time);
    end
  endtask : check_bit

  // the first period may lose one fast edge to synchroniser phase
  task automatic check_acc(input logic [15:0] got, input int exp);
    tests_run++;
    if ($isunknown(got) || got > exp || got + 1 < exp) begin
      miscompares++;
      $display("CHECK FAILED at %0t: count %0d", $time, got);
    end
  endtask : check_acc

  // the squarer carries the chosen sensor only: 4 or 6 high of 8 cycles
  task automatic check_square(input int exp_high);
    int hi;
    hi = 0;
    repeat (8) begin
      @(posedge clk);
      #1;
      hi += squarer_in;
    end
    check_bit(hi == exp_high, 1'b1);
  endtask : check_square

  task automatic test_done;
    $display("checks %0d, mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : test_done

  task automatic issue(input logic [3:0] code);
    @(posedge clk) decoded_control_lines <= code;
    @(posedge clk) decoded_control_lines <= 4'h0;
    #1;
  endtask : issue

  task automatic wait_done;
    int n;
    n = 0;
    while (measure_done !== 1'b1 && n < 4000) begin
      @(posedge clk);
      #1;
      n++;
    end
    check_bit(measure_done, 1'b1);
    if (measure_done !== 1'b1) test_done();
  endtask : wait_done

  task automatic read_half(input logic fine, output logic [7:0] d);
    @(posedge clk) begin
      index_word <= {7'h00, fine};
      input_strobe <= 1'b1;
    end
    @(posedge clk) begin
      input_strobe <= 1'b0;
      input_data_enable <= 1'b1;
    end
    @(posedge clk) input_data_enable <= 1'b0;
    #1;
    check_bit(input_data_valid, 1'b1);
    d = input_data;
  endtask : read_half

  // ********************
  // scenarios
  // ********************
  task automatic t_static;
    issue(`SFC_CTL_STATIC);
    check_bit(static_channel_select, 1'b1);
    check_bit(count_seq_static, 1'b1);
    check_bit(route_total, 1'b0);
    check_bit(measure_busy, 1'b1);
    wait_done();
    check_bit(measure_busy, 1'b0);
    check_square(4);
    read_half(1'b0, v[15:8]);
    read_half(1'b1, v[7:0]);
    check_acc(v, EXP_S);
    repeat (50) @(posedge clk);
    read_half(1'b0, v[15:8]);
    check_acc(v, EXP_S);
  endtask : t_static

  task automatic t_total;
    issue(`SFC_CTL_TOTAL);
    check_bit(total_channel_select, 1'b1);
    check_bit(count_seq_total, 1'b1);
    check_bit(route_static, 1'b0);
    wait_done();
    check_bit(cycle_count === 8'h00, 1'b1);
    check_square(6);
    read_half(1'b1, v[7:0]);
    read_half(1'b0, v[15:8]);
    check_acc(v, EXP_T);
  endtask : t_total

  // a static start in mid total measurement must begin from the static preload
  task automatic t_restart;
    issue(`SFC_CTL_TOTAL);
    repeat (300) @(posedge clk);
    issue(`SFC_CTL_STATIC);
    check_bit(cycle_count === 8'hc7, 1'b1);
    wait_done();
    read_half(1'b0, v[15:8]);
    read_half(1'b1, v[7:0]);
    check_acc(v, EXP_S);
  endtask : t_restart

  task automatic t_latch;
    issue(`SFC_CTL_LATCH);
    check_bit(converter_latch_strobe, 1'b1);
    check_bit(static_channel_select, 1'b0);
    @(posedge clk);
    #1;
    check_bit(converter_latch_strobe, 1'b0);
  endtask : t_latch

  // strobe and enable together read with the old (fine) selection
  task automatic t_order;
    @(posedge clk) begin
      index_word <= 8'h00;
      input_strobe <= 1'b1;
      input_data_enable <= 1'b1;
    end
    @(posedge clk) input_strobe <= 1'b0;
    #1;
    check_bit(input_data === v[7:0], 1'b1);
    // enable still high: this read uses the coarse request just latched
    @(posedge clk) input_data_enable <= 1'b0;
    #1;
    check_bit(input_data === v[15:8], 1'b1);
  endtask : t_order

  initial begin
    repeat (4) @(posedge clk);
    reset <= 1'b0;
    t_static();
    t_total();
    t_restart();
    t_latch();
    t_order();
    test_done();
  end
endmodule : sfc_converter_tb

// ---- testbench/sfc_sensor_model.sv ----
`timescale 1ns/1ps

// ********************
// sensor and fast clock source
// ********************
module sfc_sensor_model
  import sfc_pkg::*;
(
  // clock
  input wire logic clk,
  // sensor pins and fast clock
  output logic sensor_static,
  output logic sensor_total,
  output logic hs_clock
);
  logic [2:0] ph_q = 3'h0;
  logic hs_q = 1'b0;

  // locked to clk so counts are exact; duty cycles differ (4 vs 6 of 8)
  // so a wrongly routed sensor shows up in the result
  always @(posedge clk) begin
    ph_q <= ph_q + 3'h1;
    hs_q <= ~hs_q;
  end
  assign sensor_static = ph_q < 3'h4;
  assign sensor_total = ph_q < 3'h6;
  assign hs_clock = hs_q;
endmodule : sfc_sensor_model
